// ==== ppf_port.sv ====
// Port B and port A pin function control with an APB register slave.
`timescale 1ns/10ps
module ppf_port
   import ppf_pkg::*;
#(
   parameter int W = PORT_W
) (
   // Clock, reset and standby controls.
   input  wire logic              clk_in,
   input  wire logic              srst_in,
   input  wire logic              hw_standby_in,
   input  wire logic              sw_standby_in,
   // APB slave.
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [ADDR_W-1:0] paddr_in,
   input  wire logic [31:0]       pwdata_in,
   input  wire logic [3:0]        pstrb_in,
   output logic      [31:0]       prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   // Alternate output sources from other blocks.
   input  wire logic              pattern_pulse_out_0_in,
   input  wire logic              pattern_pulse_out_1_in,
   input  wire logic              pattern_pulse_out_15_in,
   input  wire logic              transfer_end_out_0_in,
   input  wire logic              transfer_end_out_1_in,
   // Port B pins.
   input  wire logic [W-1:0]      pb_in,
   output logic      [W-1:0]      pb_out,
   output logic      [W-1:0]      pb_oe_n_out,
   // Port A pins one and zero.
   input  wire logic [1:0]        pa_in,
   output logic      [1:0]        pa_out,
   output logic      [1:0]        pa_oe_n_out,
   // Alternate inputs routed to other blocks.
   output logic                   dma1_request_n_out,
   output logic                   converter_trigger_n_out,
   output logic                   timer_ext_clock_a_out,
   output logic                   timer_ext_clock_b_out
);

   // Register state.
   logic [W-1:0] port_b_direction;
   logic [W-1:0] port_b_output_latch;
   logic [15:0]  cfg;
   logic [15:0]  dma_sel;
   logic [15:0]  presc;

   // Filtered pin levels.
   logic [W-1:0] pb_level;
   logic [1:0]   pa_level;

   // Bus decode.
   logic         acc_done;
   logic         acc_start;
   logic         wr_en;
   logic [15:0]  idx;
   logic         idx_hit;
   logic [31:0]  next_prdata;
   logic [15:0]  wmask;

   // Pin function selections.
   logic         setting_one_0;
   logic         setting_one_1;
   logic         clk_a_sel;
   logic         clk_b_sel;
   logic [W-1:0] next_pb_out;
   logic [1:0]   next_pa_out;
   logic [1:0]   next_pa_oe_n;
   logic         frozen;
   logic         cleared;

   assign cleared = srst_in | hw_standby_in;
   assign frozen  = sw_standby_in;

   // Pins pass the three-stage filter before any use.
   ppf_sync #(.W(W)) u_sync_b (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .async_in  (pb_in),
      .level_out (pb_level)
   );

   ppf_sync #(.W(2)) u_sync_a (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .async_in  (pa_in),
      .level_out (pa_level)
   );

   // Both transfer channels share one decoder design.
   ppf_dma_decode u_dec0 (
      .sel_in          (dma_sel[DMA_CH0 +: DMA_SEL_W]),
      .setting_one_out (setting_one_0)
   );

   ppf_dma_decode u_dec1 (
      .sel_in          (dma_sel[DMA_CH1 +: DMA_SEL_W]),
      .setting_one_out (setting_one_1)
   );

   // The access phase waits one cycle so that all answers are registered.
   assign acc_start = psel_in & penable_in & ~pready_out;
   assign acc_done  = psel_in & penable_in & pready_out;
   assign idx       = paddr_in[17:2];
   assign idx_hit   = (paddr_in[1:0] == 2'h0) &&
                      ((idx == IDX_PB_DIR) || (idx == IDX_PB_DATA) ||
                       (idx == IDX_CFG) || (idx == IDX_DMA) ||
                       (idx == IDX_PRESC));
   assign wr_en     = acc_done & pwrite_in & idx_hit & ~frozen;
   assign wmask     = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};

   // Ready and error answer, valid at the edge that ends the transfer.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out  <= acc_start;
         pslverr_out <= acc_start & ~idx_hit;
      end
   end

   // Read data mux; unmapped reads return zero.
   always_comb begin
      next_prdata = 32'h0000_0000;
      unique case (1'b1)
         idx_hit && (idx == IDX_PB_DIR):
            next_prdata = DIR_READBACK;
         idx_hit && (idx == IDX_PB_DATA):
            next_prdata[W-1:0] =
               (port_b_output_latch & port_b_direction) |
               (pb_level & ~port_b_direction);
         idx_hit && (idx == IDX_CFG): begin
            next_prdata[15:0] = cfg;
            next_prdata[CFG_PA_LAT +: 2] =
               (cfg[CFG_PA_LAT +: 2] & cfg[CFG_PA_DIR +: 2]) |
               (pa_level & ~cfg[CFG_PA_DIR +: 2]);
         end
         idx_hit && (idx == IDX_DMA):
            next_prdata[15:0] = dma_sel;
         idx_hit && (idx == IDX_PRESC):
            next_prdata[15:0] = presc;
         default:
            next_prdata = 32'h0000_0000;
      endcase
   end

   // Read data is captured at the same edge as ready rises.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         prdata_out <= 32'h0000_0000;
      end else if (acc_start && !pwrite_in) begin
         prdata_out <= next_prdata;
      end
   end

   // Port B registers; hardware standby clears, software standby holds.
   always_ff @(posedge clk_in) begin
      if (cleared) begin
         port_b_direction    <= PB_DIR_RST;
         port_b_output_latch <= PB_DATA_RST;
      end else if (wr_en && pstrb_in[0]) begin
         if (idx == IDX_PB_DIR) begin
            port_b_direction <= pwdata_in[W-1:0];
         end
         if (idx == IDX_PB_DATA) begin
            port_b_output_latch <= pwdata_in[W-1:0];
         end
      end
   end

   // Selection registers gathered from neighbouring blocks.
   always_ff @(posedge clk_in) begin
      if (cleared) begin
         cfg     <= CFG_RST;
         dma_sel <= DMA_RST;
         presc   <= PRESC_RST;
      end else if (wr_en) begin
         if (idx == IDX_CFG) begin
            cfg <= (cfg & ~wmask) | (pwdata_in[15:0] & wmask);
         end
         if (idx == IDX_DMA) begin
            dma_sel <= (dma_sel & ~wmask) | (pwdata_in[15:0] & wmask);
         end
         if (idx == IDX_PRESC) begin
            presc <= (presc & ~wmask) | (pwdata_in[15:0] & wmask);
         end
      end
   end

   // Any timer channel selecting an external clock claims the pin.
   always_comb begin
      clk_a_sel = cfg[CFG_PHASE];
      clk_b_sel = cfg[CFG_PHASE];
      for (int c = 0; c < TIMER_CH; c++) begin
         if (presc[c*PSC_W +: PSC_W] == PSC_CLK_A) begin
            clk_a_sel = 1'b1;
         end
         if (presc[c*PSC_W +: PSC_W] == PSC_CLK_B) begin
            clk_b_sel = 1'b1;
         end
      end
   end

   // Port B output value per pin; only pin seven has an alternate.
   for (genvar i = 0; i < W; i++) begin : g_pb
      if (i == W - 1) begin : g_alt
         assign next_pb_out[i] = cfg[CFG_PE15] ?
            pattern_pulse_out_15_in : port_b_output_latch[i];
      end else begin : g_plain
         assign next_pb_out[i] = port_b_output_latch[i];
      end
   end

   // Port A pins one and zero: transfer end wins in setting one.
   always_comb begin
      next_pa_oe_n = ~cfg[CFG_PA_DIR +: 2];
      next_pa_out[0] = cfg[CFG_PE0] ?
         pattern_pulse_out_0_in : cfg[CFG_PA_LAT];
      next_pa_out[1] = cfg[CFG_PE1] ?
         pattern_pulse_out_1_in : cfg[CFG_PA_LAT + 1];
      if (setting_one_0) begin
         next_pa_out[0]  = transfer_end_out_0_in;
         next_pa_oe_n[0] = 1'b0;
      end
      if (setting_one_1) begin
         next_pa_out[1]  = transfer_end_out_1_in;
         next_pa_oe_n[1] = 1'b0;
      end
   end

   // Pin drivers are frozen in software standby so outputs hold.
   always_ff @(posedge clk_in) begin
      if (cleared) begin
         pb_out      <= '0;
         pb_oe_n_out <= '1;
         pa_out      <= 2'h0;
         pa_oe_n_out <= 2'h3;
      end else if (!frozen) begin
         pb_out      <= next_pb_out;
         pb_oe_n_out <= ~port_b_direction;
         pa_out      <= next_pa_out;
         pa_oe_n_out <= next_pa_oe_n;
      end
   end

   // Alternate inputs read the same filtered level as port reads.
   always_ff @(posedge clk_in) begin
      if (cleared) begin
         dma1_request_n_out      <= 1'b1;
         converter_trigger_n_out <= 1'b1;
         timer_ext_clock_a_out   <= 1'b0;
         timer_ext_clock_b_out   <= 1'b0;
      end else begin
         dma1_request_n_out <= setting_one_1 ?
            pb_level[W-1] : 1'b1;
         converter_trigger_n_out <= cfg[CFG_TRG] ?
            pb_level[W-1] : 1'b1;
         timer_ext_clock_a_out <= clk_a_sel & pa_level[0];
         timer_ext_clock_b_out <= clk_b_sel & pa_level[1];
      end
   end

   // Checks on the behaviour above.
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   a_dir_reads_ones: assert property (
      (acc_start && !pwrite_in && idx_hit && idx == IDX_PB_DIR)
      |=> prdata_out == DIR_READBACK ##0 pready_out)
      else $error("direction read did not return all ones");

   a_data_read_mix: assert property (
      (acc_start && !pwrite_in && idx_hit && idx == IDX_PB_DATA)
      |=> prdata_out[W-1:0] ==
          (($past(port_b_output_latch) & $past(port_b_direction)) |
           ($past(pb_level) & ~$past(port_b_direction))))
      else $error("port data read mixed latch and pin wrongly");

   a_hw_standby_clear: assert property (
      hw_standby_in |=> port_b_direction == PB_DIR_RST &&
                        port_b_output_latch == PB_DATA_RST &&
                        pb_oe_n_out == '1)
      else $error("hardware standby did not clear the port");

   a_sw_standby_hold: assert property (
      (sw_standby_in && !hw_standby_in)
      |=> $stable(pb_out) && $stable(pb_oe_n_out))
      else $error("pins changed during software standby");

   a_dir_drives_pin: assert property (
      (!sw_standby_in && !hw_standby_in)
      |=> pb_oe_n_out == ~$past(port_b_direction))
      else $error("pin enable does not follow direction");

   a_pin7_pulse: assert property (
      (!frozen && !hw_standby_in && cfg[CFG_PE15])
      |=> pb_out[W-1] == $past(pattern_pulse_out_15_in))
      else $error("pin seven did not carry the pattern pulse");

   a_latch_write: assert property (
      (wr_en && pstrb_in[0] && idx == IDX_PB_DATA && !hw_standby_in)
      |=> port_b_output_latch == $past(pwdata_in[W-1:0]))
      else $error("latch write was lost");

   a_trigger_route: assert property (
      (!hw_standby_in && cfg[CFG_TRG])
      |=> converter_trigger_n_out == $past(pb_level[W-1]))
      else $error("converter trigger not routed from pin seven");

   a_dma_request: assert property (
      (!hw_standby_in && !setting_one_1) |=> dma1_request_n_out)
      else $error("transfer request active outside setting one");

   a_pa1_tend: assert property (
      (!frozen && !hw_standby_in && setting_one_1)
      |=> !pa_oe_n_out[1] && pa_out[1] == $past(transfer_end_out_1_in))
      else $error("port A pin one lost the transfer end output");

   a_clock_b_gate: assert property (
      (!hw_standby_in && !clk_b_sel) |=> !timer_ext_clock_b_out)
      else $error("timer clock B passed while deselected");

endmodule

// ==== ppf_pkg.sv ====
// Shared constants for the port pin function control block.
package ppf_pkg;

   // Port width and bus address width.
   localparam int PORT_W = 8;
   localparam int ADDR_W = 18;

   // Register indexes; the byte address is four times the index.
   localparam logic [15:0] IDX_PB_DIR  = 16'hFFD4;
   localparam logic [15:0] IDX_PB_DATA = 16'hFFD6;
   localparam logic [15:0] IDX_CFG     = 16'hFFD8;
   localparam logic [15:0] IDX_DMA     = 16'hFFDA;
   localparam logic [15:0] IDX_PRESC   = 16'hFFDC;

   // Reset values and the direction register read value.
   localparam logic [7:0]  PB_DIR_RST   = 8'h00;
   localparam logic [7:0]  PB_DATA_RST  = 8'h00;
   localparam logic [15:0] CFG_RST      = 16'h0000;
   localparam logic [15:0] DMA_RST      = 16'h0000;
   localparam logic [15:0] PRESC_RST    = 16'h0000;
   localparam logic [31:0] DIR_READBACK = 32'h0000_00FF;

   // Configuration register fields.
   localparam int CFG_PE0    = 0;
   localparam int CFG_PE1    = 1;
   localparam int CFG_PE15   = 2;
   localparam int CFG_TRG    = 3;
   localparam int CFG_PHASE  = 4;
   localparam int CFG_PA_DIR = 8;
   localparam int CFG_PA_LAT = 12;

   // Transfer-source select fields: channel base, then bit in group.
   localparam int DMA_CH0   = 0;
   localparam int DMA_CH1   = 8;
   localparam int DMA_SEL_W = 5;
   localparam int DMA_AHI   = 4;
   localparam int DMA_AMID  = 3;
   localparam int DMA_ALO   = 2;
   localparam int DMA_BHI   = 1;
   localparam int DMA_BMID  = 0;

   // Prescaler select fields: five 3-bit fields from bit 0.
   localparam int          TIMER_CH  = 5;
   localparam int          PSC_W     = 3;
   localparam logic [2:0]  PSC_CLK_A = 3'h4;
   localparam logic [2:0]  PSC_CLK_B = 3'h5;

endpackage

// ==== ppf_sync.sv ====
// Three-stage input synchroniser that accepts a change once stages agree.
`timescale 1ns/10ps
module ppf_sync
   import ppf_pkg::*;
#(
   parameter int W = PORT_W
) (
   // Clock and reset.
   input  wire logic         clk_in,
   input  wire logic         srst_in,
   // Raw pin levels and filtered result.
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] level_out
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   // Shift chain; stage1 feeds stage2 alone to keep metastability away.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Each bit only moves when the last two stages agree.
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_in) begin
         if (srst_in) begin
            level_out[i] <= 1'b0;
         end else if (stage2[i] == stage3[i]) begin
            level_out[i] <= stage3[i];
         end
      end
   end

endmodule

// ==== ppf_dma_decode.sv ====
// Decoder of one transfer channel's source select into setting one.
`timescale 1ns/10ps
module ppf_dma_decode
   import ppf_pkg::*;
(
   // Five select bits of one channel.
   input  wire logic [DMA_SEL_W-1:0] sel_in,
   // High when the channel is in setting one.
   output logic                      setting_one_out
);

   logic a_both;

   // Setting one covers nine select codes from three product terms; all else is setting two.
   always_comb begin
      a_both = sel_in[DMA_AHI] & sel_in[DMA_AMID];
      setting_one_out =
         (~a_both & sel_in[DMA_BHI] & sel_in[DMA_BMID]) |
         (a_both & ~sel_in[DMA_ALO] & sel_in[DMA_BHI]) |
         (a_both & sel_in[DMA_ALO] & sel_in[DMA_BHI] &
          sel_in[DMA_BMID]);
   end

endmodule

// ==== ppf_board_model.sv ====
// Board-side model that resolves the levels on the port pins.
`timescale 1ns/10ps
module ppf_board_model
   import ppf_pkg::*;
(
   // Levels the board applies where the port is not driving.
   input  wire logic [PORT_W-1:0] board_pb_in,
   input  wire logic [1:0]        board_pa_in,
   // Port drivers.
   input  wire logic [PORT_W-1:0] pb_in,
   input  wire logic [PORT_W-1:0] pb_oe_n_in,
   input  wire logic [1:0]        pa_in,
   input  wire logic [1:0]        pa_oe_n_in,
   // Resolved wire levels.
   output logic      [PORT_W-1:0] pb_level_out,
   output logic      [1:0]        pa_level_out
);
   // A driven pin shows the port's value, so the board drive is weaker.
   assign pb_level_out = (pb_oe_n_in & board_pb_in) | (~pb_oe_n_in & pb_in);
   assign pa_level_out = (pa_oe_n_in & board_pa_in) | (~pa_oe_n_in & pa_in);
endmodule

// ==== ppf_port_tb_top.sv ====
// Self-checking testbench for the port pin function control block.
`timescale 1ns/10ps
module ppf_port_tb_top
   import ppf_pkg::*;
;
   logic              clk_in, srst_in, hw_sb, sw_sb;
   logic              psel, penable, pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata;
   logic [3:0]        pstrb;
   logic              pready, pslverr, pp0, pp1, pp15, te0, te1;
   logic [7:0]        board_pb, pb_lvl, pb_out, pb_oe_n;
   logic [1:0]        board_pa, pa_lvl, pa_out, pa_oe_n;
   logic              req_n, trg_n, tca, tcb;
   int                err_total, samples_checked;

   // Design under test.
   ppf_port uut (
      .clk_in(clk_in), .srst_in(srst_in), .hw_standby_in(hw_sb),
      .sw_standby_in(sw_sb), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .pattern_pulse_out_0_in(pp0),
      .pattern_pulse_out_1_in(pp1), .pattern_pulse_out_15_in(pp15),
      .transfer_end_out_0_in(te0), .transfer_end_out_1_in(te1),
      .pb_in(pb_lvl), .pb_out(pb_out), .pb_oe_n_out(pb_oe_n),
      .pa_in(pa_lvl), .pa_out(pa_out), .pa_oe_n_out(pa_oe_n),
      .dma1_request_n_out(req_n), .converter_trigger_n_out(trg_n),
      .timer_ext_clock_a_out(tca), .timer_ext_clock_b_out(tcb));

   // Board on the far side of the pins.
   ppf_board_model board (
      .board_pb_in(board_pb), .board_pa_in(board_pa), .pb_in(pb_out),
      .pb_oe_n_in(pb_oe_n), .pa_in(pa_out), .pa_oe_n_in(pa_oe_n),
      .pb_level_out(pb_lvl), .pa_level_out(pa_lvl));

   // Clock at 25 MHz.
   always #20 clk_in = ~clk_in;

   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; the request holds until pready is sampled high.
   task automatic apb(input logic wr, input logic [15:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      int n;
      @(posedge clk_in);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      pstrb   <= 4'hF;
      @(posedge clk_in);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         err_total++;
         close_out;
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] idx, input logic [31:0] d);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, idx, d, rd, er);
   endtask

   task automatic rdchk(input logic [15:0] idx, input logic [31:0] e);
      logic [31:0] rd;
      logic        er;
      apb(1'b0, idx, 32'h0000_0000, rd, er);
      chk(rd, e);
   endtask

   // Long enough for the register, the input filter and the output flops.
   task automatic settle;
      repeat (8) @(posedge clk_in);
   endtask

   function automatic logic set_one(input logic [4:0] s);
      return (!(s[4] & s[3]) & s[1] & s[0]) | (s[4] & s[3] & !s[2] & s[1])
             | (&s);
   endfunction

   // Guard against a hang anywhere in the run.
   initial begin
      repeat (100000) @(posedge clk_in);
      err_total++;
      close_out;
   end

   // Main sequence.
   initial begin
      logic [31:0] rd;
      logic        er;
      logic [4:0]  s5;
      logic        e;
      clk_in = 1'b0; srst_in = 1'b1; hw_sb = 1'b0; sw_sb = 1'b0;
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
      pwdata = '0; pstrb = 4'h0; pp0 = 1'b0; pp1 = 1'b0; pp15 = 1'b0;
      te0 = 1'b1; te1 = 1'b0; board_pb = 8'h5A; board_pa = 2'b11;
      err_total = 0; samples_checked = 0;
      repeat (12) @(posedge clk_in);
      srst_in <= 1'b0;
      settle;
      chk(32'(pb_oe_n), 32'h0000_00FF);
      chk(32'(pb_out), 32'h0000_0000);
      rdchk(IDX_PB_DIR, 32'h0000_00FF);
      rdchk(IDX_PB_DATA, 32'h0000_005A);
      wr(IDX_PB_DATA, 32'h0000_00C3);
      settle;
      chk(32'(pb_oe_n), 32'h0000_00FF);
      wr(IDX_PB_DIR, 32'h0000_008F);
      settle;
      chk(32'(pb_oe_n), 32'h0000_0070);
      chk(32'(pb_out & ~pb_oe_n), 32'h0000_0083);
      rdchk(IDX_PB_DATA, 32'h0000_00D3);
      rdchk(IDX_PB_DIR, 32'h0000_00FF);
      // Pin seven switches between latch and pattern pulse.
      wr(IDX_CFG, 32'h0000_0004);
      settle;
      chk(32'(pb_out[7]), 32'h0000_0000);
      pp15 <= 1'b1;
      settle;
      chk(32'(pb_out[7]), 32'h0000_0001);
      wr(IDX_CFG, 32'h0000_0000);
      // Writes in software standby are ignored and drivers hold.
      sw_sb <= 1'b1;
      wr(IDX_PB_DATA, 32'h0000_0000);
      wr(IDX_PB_DIR, 32'h0000_0000);
      settle;
      chk(32'(pb_oe_n), 32'h0000_0070);
      chk(32'(pb_out & ~pb_oe_n), 32'h0000_0083);
      sw_sb <= 1'b0;
      rdchk(IDX_PB_DATA, 32'h0000_00D3);
      // Hardware standby clears both registers.
      hw_sb <= 1'b1;
      settle;
      chk(32'(pb_oe_n), 32'h0000_00FF);
      hw_sb <= 1'b0;
      wr(IDX_PB_DIR, 32'h0000_00FF);
      rdchk(IDX_PB_DATA, 32'h0000_0000);
      wr(IDX_PB_DIR, 32'h0000_0000);
      // An unmapped location answers with an error and zero data.
      apb(1'b0, 16'hFFDE, 32'h0000_0000, rd, er);
      chk(32'(er), 32'h0000_0001);
      chk(rd, 32'h0000_0000);
      // Converter trigger follows pin seven while port reads still work.
      wr(IDX_CFG, 32'h0000_0008);
      settle;
      chk(32'(trg_n), 32'h0000_0000);
      rdchk(IDX_PB_DATA, 32'h0000_005A);
      board_pb <= 8'hDA;
      settle;
      chk(32'(trg_n), 32'h0000_0001);
      board_pb <= 8'h5A;
      wr(IDX_CFG, 32'h0000_0000);
      settle;
      chk(32'(trg_n), 32'h0000_0001);
      // Every source select code on both channels.
      for (int s = 0; s < 32; s++) begin
         s5 = 5'(s);
         e = set_one(s5);
         // Opposite transfer end levels show each pin's own source.
         te0 <= s5[0];
         te1 <= !s5[0];
         wr(IDX_DMA, {19'h0, s5, 3'h0, s5});
         settle;
         chk(32'(req_n), 32'(!e));
         chk(32'(pa_oe_n), e ? 32'h0 : 32'h3);
         if (e) begin
            chk(32'(pa_out), {30'h0, !s5[0], s5[0]});
         end
      end
      wr(IDX_DMA, 32'h0000_0000);
      // Port A as port output and pattern pulse output.
      wr(IDX_CFG, 32'h0000_3302);
      settle;
      chk(32'(pa_oe_n), 32'h0000_0000);
      chk(32'(pa_out), 32'h0000_0001);
      pp1 <= 1'b1;
      wr(IDX_CFG, 32'h0000_3301);
      settle;
      chk(32'(pa_out), 32'h0000_0002);
      pp0 <= 1'b1;
      settle;
      chk(32'(pa_out), 32'h0000_0003);
      wr(IDX_CFG, 32'h0000_0000);
      // External timer clocks from each prescaler field.
      for (int i = 0; i < 5; i++) begin
         wr(IDX_PRESC, 32'h0000_0004 << (3 * i));
         settle;
         chk(32'({tcb, tca}), 32'h0000_0001);
         wr(IDX_PRESC, 32'h0000_0005 << (3 * i));
         settle;
         chk(32'({tcb, tca}), 32'h0000_0002);
      end
      wr(IDX_PRESC, 32'h0000_0000);
      settle;
      chk(32'({tcb, tca}), 32'h0000_0000);
      wr(IDX_CFG, 32'h0000_0010);
      settle;
      chk(32'({tcb, tca}), 32'h0000_0003);
      close_out;
   end
endmodule
